/* src/dmau_core.sv */
// data memory address unit: direct, common bank and indirect addressing
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dmau_core
   import dmau_pkg::*;
#(
   parameter logic [15:0] BANK_EN_DEFAULT = BANK_EN_RESET
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire dmau_req_t core_req,
   output dmau_rsp_t core_rsp,
   output dmau_ram_t ram_req,
   input wire logic [7:0] ram_rdata,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   function automatic logic is_port(input logic [11:0] a);
      return (a >= SFR_PORT_BASE) && (a < SFR_PORT_BASE + 12'(NUM_PTRS));
   endfunction

   function automatic logic is_ptr_sfr(input logic [11:0] a);
      return (a >= SFR_PTR_BASE) && (a < SFR_PTR_BASE + 12'(2 * NUM_PTRS));
   endfunction

   logic [7:0] ram_bank_selector_reg;
   logic [11:0] indirect_pointer_reg [NUM_PTRS];
   logic [15:0] bank_en_reg;
   logic [11:0] last_addr_reg;
   logic last_null_reg;
   logic wb_hit;
   logic [7:0] wb_off;
   logic [11:0] direct_ea;
   logic [11:0] eff_ea;
   logic [1:0] port_idx;
   logic [2:0] ptr_byte;
   logic ea_port;
   logic ea_null;
   logic ea_local;
   logic ea_impl;
   logic [7:0] local_rdata;
   logic acc_valid;
   dmau_src_t src_reg;
   logic [7:0] local_reg;
   logic flag_pend_reg;
   logic rd_pend_reg;

   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wb_off = wb_adr_i - OFS_PTR_BASE;
   assign acc_valid = (core_req.op == OP_READ) || (core_req.op == OP_WRITE);

   // address before any indirection
   always_comb begin
      if (core_req.full_addr) begin
         direct_ea = core_req.addr12; // R10
      end else if (!core_req.access_bit) begin
         // low half from the first bank, high half from the sfr bank
         if (core_req.file_addr < COMMON_SPLIT) begin
            direct_ea = {FIRST_BANK, core_req.file_addr}; // R1 R3
         end else begin
            direct_ea = {LAST_BANK, core_req.file_addr}; // R1 R3
         end
      end else begin
         direct_ea = {ram_bank_selector_reg[3:0], core_req.file_addr}; // R2 R5 R17
      end
   end

   // indirection and target classification
   always_comb begin
      ea_port = is_port(direct_ea);
      port_idx = 2'(direct_ea - SFR_PORT_BASE);
      eff_ea = direct_ea;
      if (ea_port) begin
         eff_ea = indirect_pointer_reg[port_idx]; // R11
      end
      // the port addresses hold nothing; only a pointer aimed at one lands here
      ea_null = ea_port && is_port(eff_ea); // R13 R14 R15
      ea_local = !ea_null && (eff_ea == SFR_BANK_SEL || is_ptr_sfr(eff_ea));
      ea_impl = bank_en_reg[eff_ea[11:8]]; // R4 R7
      ptr_byte = 3'(eff_ea - SFR_PTR_BASE);
      local_rdata = 8'h00;
      if (eff_ea == SFR_BANK_SEL) begin
         local_rdata = ram_bank_selector_reg; // R6
      end else if (is_ptr_sfr(eff_ea)) begin
         if (ptr_byte[0]) begin
            local_rdata = {4'h0, indirect_pointer_reg[ptr_byte[2:1]][11:8]};
         end else begin
            local_rdata = indirect_pointer_reg[ptr_byte[2:1]][7:0];
         end
      end
   end

   // bank selector: core wins over the register bus in the same cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ram_bank_selector_reg <= BANK_SEL_RESET;
      end else if (core_req.op == OP_LOAD_BANK) begin
         ram_bank_selector_reg <= {4'h0, core_req.literal}; // R9 R6
      end else if (core_req.op == OP_WRITE && ea_local && eff_ea == SFR_BANK_SEL) begin
         ram_bank_selector_reg <= {4'h0, core_req.wdata[3:0]}; // R6
      end else if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_BANK_SEL) begin
         ram_bank_selector_reg <= {4'h0, wb_dat_i[3:0]}; // R6
      end
   end

   // pointers, low and high byte each
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NUM_PTRS; i++) begin
            indirect_pointer_reg[i] <= PTR_RESET;
         end
      end else if (core_req.op == OP_WRITE && ea_local && is_ptr_sfr(eff_ea)) begin
         if (ptr_byte[0]) begin
            indirect_pointer_reg[ptr_byte[2:1]][11:8] <= core_req.wdata[3:0]; // R12 R16
         end else begin
            indirect_pointer_reg[ptr_byte[2:1]][7:0] <= core_req.wdata; // R16
         end
      end else if (wb_hit && wb_we_i && wb_sel_i[0] && wb_off[1:0] == 2'h0
                   && wb_off[7:2] < 6'(2 * NUM_PTRS) && wb_adr_i >= OFS_PTR_BASE) begin
         if (wb_off[2]) begin
            indirect_pointer_reg[wb_off[4:3]][11:8] <= wb_dat_i[3:0]; // R12 R16
         end else begin
            indirect_pointer_reg[wb_off[4:3]][7:0] <= wb_dat_i[7:0]; // R16
         end
      end
   end

   // bank presence mask lets software hide banks that have no memory
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         bank_en_reg <= BANK_EN_DEFAULT;
      end else if (wb_hit && wb_we_i && wb_adr_i == OFS_BANK_EN) begin
         if (wb_sel_i[0]) begin
            bank_en_reg[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            bank_en_reg[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   // stage one: ram request
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ram_req <= '0;
         src_reg <= SRC_ZERO;
         local_reg <= 8'h00;
         flag_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
      end else begin
         ram_req.en <= acc_valid && !ea_null && !ea_local && ea_impl; // R7 R14
         ram_req.we <= core_req.op == OP_WRITE && !ea_null && !ea_local && ea_impl; // R7 R14
         ram_req.addr <= eff_ea;
         ram_req.wdata <= core_req.wdata;
         local_reg <= local_rdata;
         rd_pend_reg <= acc_valid;
         // unimplemented banks keep flag behaviour; a null write is a plain no-op
         flag_pend_reg <= acc_valid && core_req.flags_req
                          && !(ea_null && core_req.op == OP_WRITE); // R8 R14
         if (ea_null || (!ea_local && !ea_impl)) begin
            src_reg <= SRC_ZERO; // R7 R13
         end else if (ea_local) begin
            src_reg <= SRC_LOCAL;
         end else begin
            src_reg <= SRC_RAM;
         end
      end
   end

   // stage two: answer to the core
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         core_rsp <= '0;
      end else begin
         core_rsp.valid <= rd_pend_reg;
         core_rsp.flag_update <= flag_pend_reg; // R8
         unique case (src_reg)
            SRC_RAM: core_rsp.rdata <= ram_rdata;
            SRC_LOCAL: core_rsp.rdata <= local_reg;
            SRC_ZERO: core_rsp.rdata <= 8'h00; // R7 R13
         endcase
      end
   end

   // last resolved address, visible to software
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         last_addr_reg <= 12'h000;
         last_null_reg <= 1'b0;
      end else if (acc_valid) begin
         last_addr_reg <= eff_ea;
         last_null_reg <= ea_null;
      end
   end

   // register bus: one wait state, unmapped reads zero
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_hit;
         wb_dat_o <= 32'h0000_0000;
         if (wb_hit && !wb_we_i) begin
            if (wb_adr_i == OFS_BANK_SEL) begin
               wb_dat_o <= {24'h00_0000, ram_bank_selector_reg}; // R6
            end else if (wb_adr_i == OFS_BANK_EN) begin
               wb_dat_o <= {16'h0000, bank_en_reg};
            end else if (wb_adr_i == OFS_STATUS) begin
               wb_dat_o <= {19'h0_0000, last_null_reg, last_addr_reg};
            end else if (wb_adr_i >= OFS_PTR_BASE && wb_off[1:0] == 2'h0
                         && wb_off[7:2] < 6'(2 * NUM_PTRS)) begin
               if (wb_off[2]) begin
                  wb_dat_o <= {28'h000_0000, indirect_pointer_reg[wb_off[4:3]][11:8]};
               end else begin
                  wb_dat_o <= {24'h00_0000, indirect_pointer_reg[wb_off[4:3]][7:0]};
               end
            end
         end
      end
   end

   a_common_low: assert property (@(posedge clk_sys) disable iff (!reset_n) // R1 R3
      (acc_valid && !core_req.full_addr && !core_req.access_bit && core_req.file_addr < COMMON_SPLIT
       && bank_en_reg[0]) |=> ram_req.en && ram_req.addr == {4'h0, $past(core_req.file_addr)})
      else $error("common bank low half misaddressed");

   a_common_high: assert property (@(posedge clk_sys) disable iff (!reset_n) // R2 R3
      (acc_valid && !core_req.full_addr && !core_req.access_bit && !ea_port)
      |=> ram_req.addr[11:8] == ($past(core_req.file_addr[7]) ? 4'hf : 4'h0))
      else $error("common bank half select wrong");

   a_banked_addr: assert property (@(posedge clk_sys) disable iff (!reset_n) // R5 R17
      (acc_valid && !core_req.full_addr && core_req.access_bit && !ea_port)
      |=> ram_req.addr == {$past(ram_bank_selector_reg[3:0]), $past(core_req.file_addr)})
      else $error("banked address not formed from selector");

   a_move_addr: assert property (@(posedge clk_sys) disable iff (!reset_n) // R10
      (acc_valid && core_req.full_addr && !is_port(core_req.addr12))
      |=> ram_req.addr == $past(core_req.addr12))
      else $error("file move address altered");

   a_indirect_go: assert property (@(posedge clk_sys) disable iff (!reset_n) // R11 R12
      (acc_valid && ea_port && !ea_null)
      |=> ram_req.addr == $past(indirect_pointer_reg[port_idx]))
      else $error("indirect access not through pointer");

   a_null_read: assert property (@(posedge clk_sys) disable iff (!reset_n) // R13
      (core_req.op == OP_READ && ea_null) |=> !ram_req.en ##1 core_rsp.valid && core_rsp.rdata == 8'h00)
      else $error("pointer at port did not read zero");

   a_null_write: assert property (@(posedge clk_sys) disable iff (!reset_n) // R14 R15
      (core_req.op == OP_WRITE && ea_null) |=> !ram_req.we ##1 !core_rsp.flag_update)
      else $error("pointer at port write had an effect");

   a_missing_bank: assert property (@(posedge clk_sys) disable iff (!reset_n) // R7
      (acc_valid && !ea_local && !ea_null && !ea_impl)
      |=> !ram_req.en ##1 core_rsp.rdata == 8'h00)
      else $error("missing bank touched memory");

   a_flag_kept: assert property (@(posedge clk_sys) disable iff (!reset_n) // R8
      (core_req.op == OP_READ && core_req.flags_req && !ea_impl) |-> ##2 core_rsp.flag_update)
      else $error("flags dropped on missing bank");

   a_load_bank: assert property (@(posedge clk_sys) disable iff (!reset_n) // R9
      (core_req.op == OP_LOAD_BANK) |=> ram_bank_selector_reg == {4'h0, $past(core_req.literal)})
      else $error("literal bank load lost");

   a_selector_high: assert property (@(posedge clk_sys) disable iff (!reset_n) // R6
      (wb_ack_o && $past(wb_adr_i) == OFS_BANK_SEL) |-> wb_dat_o[7:4] == 4'h0
      && ram_bank_selector_reg[7:4] == 4'h0)
      else $error("selector upper nibble not zero");

   // pipeline guards: each access answers exactly once, two edges after it is taken
   a_rsp_follows: assert property (@(posedge clk_sys) disable iff (!reset_n) // R4
      acc_valid |-> ##2 core_rsp.valid)
      else $error("access gave no answer");

   a_rsp_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n) // R9
      (core_req.op == OP_LOAD_BANK || core_req.op == OP_NONE) |-> ##2 !core_rsp.valid)
      else $error("answer without an access");

   a_we_needs_en: assert property (@(posedge clk_sys) disable iff (!reset_n) // R7
      ram_req.we |-> ram_req.en)
      else $error("ram write strobe without enable");

   a_port_unstored: assert property (@(posedge clk_sys) disable iff (!reset_n) // R15
      ram_req.en |-> !is_port(ram_req.addr))
      else $error("indirect port address sent to ram");

   a_local_unsent: assert property (@(posedge clk_sys) disable iff (!reset_n) // R16
      (acc_valid && ea_local) |=> !ram_req.en)
      else $error("local register access reached ram");

   a_load_no_ram: assert property (@(posedge clk_sys) disable iff (!reset_n) // R9
      (core_req.op == OP_LOAD_BANK) |=> !ram_req.en)
      else $error("bank load touched ram");

   a_sfr_half: assert property (@(posedge clk_sys) disable iff (!reset_n) // R1 R3
      (acc_valid && !core_req.full_addr && !core_req.access_bit && core_req.file_addr >= COMMON_SPLIT
       && !ea_port) |=> ram_req.addr == {LAST_BANK, $past(core_req.file_addr)})
      else $error("common bank upper half misaddressed");

   // bus writes only land when the core leaves the selector alone
   a_bus_selector: assert property (@(posedge clk_sys) disable iff (!reset_n) // R5 R6
      (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_BANK_SEL && core_req.op == OP_NONE)
      |=> ram_bank_selector_reg == {4'h0, $past(wb_dat_i[3:0])})
      else $error("bus write to selector lost");

   a_core_selector: assert property (@(posedge clk_sys) disable iff (!reset_n) // R6
      (core_req.op == OP_WRITE && ea_local && eff_ea == SFR_BANK_SEL)
      |=> ram_bank_selector_reg == {4'h0, $past(core_req.wdata[3:0])})
      else $error("core write to selector wrong");

   a_ptr_low_write: assert property (@(posedge clk_sys) disable iff (!reset_n) // R16
      (core_req.op == OP_WRITE && ea_local && is_ptr_sfr(eff_ea) && !ptr_byte[0])
      |=> indirect_pointer_reg[$past(ptr_byte[2:1])][7:0] == $past(core_req.wdata))
      else $error("pointer low byte write lost");

   a_ptr_high_write: assert property (@(posedge clk_sys) disable iff (!reset_n) // R12 R16
      (core_req.op == OP_WRITE && ea_local && is_ptr_sfr(eff_ea) && ptr_byte[0])
      |=> indirect_pointer_reg[$past(ptr_byte[2:1])][11:8] == $past(core_req.wdata[3:0]))
      else $error("pointer high nibble write lost");

   a_local_read: assert property (@(posedge clk_sys) disable iff (!reset_n) // R16
      (core_req.op == OP_READ && ea_local) |-> ##2 core_rsp.rdata == $past(local_rdata, 2))
      else $error("local register read wrong");

   a_missing_no_write: assert property (@(posedge clk_sys) disable iff (!reset_n) // R7
      (acc_valid && !ea_impl) |=> !ram_req.we)
      else $error("write reached a missing bank");

   a_status_null: assert property (@(posedge clk_sys) disable iff (!reset_n) // R13
      acc_valid |=> last_null_reg == $past(ea_null) && last_addr_reg == $past(eff_ea))
      else $error("last access status not recorded");

   // read data is taken in the cycle the ram enable stands, not a cycle late
   a_ram_read_path: assert property (@(posedge clk_sys) disable iff (!reset_n) // R11
      (core_req.op == OP_READ && !ea_null && !ea_local && ea_impl)
      |=> ram_req.en && !ram_req.we ##1 core_rsp.rdata == $past(ram_rdata))
      else $error("ram read data not passed back");
endmodule
`default_nettype wire

/* src/dmau_pkg.sv */
// constants and carrier types of the data memory address unit
// Contract
// R1 - common bank: bank 15 top, bank 0 bottom
// R2 - access bit picks bank selector or common bank
// R3 - common bank: low ram followed by sfr half
// R4 - sixteen banks of 256 static ram bytes
// R5 - bank selector low nibble gives address top
// R6 - bank selector upper nibble reads zero, unwritable
// R7 - missing bank reads zeros, drops writes
// R8 - missing bank still updates status flags normally
// R9 - literal bank load writes the bank selector
// R10 - file move uses embedded 12-bit addresses
// R11 - indirect port operand redirects through its pointer
// R12 - each pointer holds a full 12-bit address
// R13 - pointer at indirect port reads 00h
// R14 - pointer at indirect port write does nothing
// R15 - no storage behind indirect port addresses
// R16 - three pointers, each high and low byte
// R17 - access bit one: bank nibble plus file address
package dmau_pkg;
   localparam int ADDR_W = 12;
   localparam int NUM_BANKS = 16;
   localparam int BANK_SIZE = 256;
   localparam int NUM_PTRS = 3;
   localparam logic [7:0] COMMON_SPLIT = 8'h80;
   localparam logic [3:0] FIRST_BANK = 4'h0;
   localparam logic [3:0] LAST_BANK = 4'hf;
   // special function register locations inside the last bank
   localparam logic [11:0] SFR_BANK_SEL = 12'hfe0;
   localparam logic [11:0] SFR_PTR_BASE = 12'hfe1;
   localparam logic [11:0] SFR_PORT_BASE = 12'hfe8;
   // register bus byte offsets
   localparam logic [7:0] OFS_BANK_SEL = 8'h00;
   localparam logic [7:0] OFS_PTR_BASE = 8'h04;
   localparam logic [7:0] OFS_BANK_EN = 8'h1c;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   localparam logic [7:0] BANK_SEL_RESET = 8'h00;
   localparam logic [11:0] PTR_RESET = 12'h000;
   localparam logic [15:0] BANK_EN_RESET = 16'hffff;

   typedef enum logic [1:0] {OP_NONE, OP_READ, OP_WRITE, OP_LOAD_BANK} dmau_op_t;
   typedef enum logic [1:0] {SRC_RAM, SRC_ZERO, SRC_LOCAL} dmau_src_t;

   typedef struct packed {
      dmau_op_t op;
      logic full_addr;
      logic access_bit;
      logic [7:0] file_addr;
      logic [ADDR_W-1:0] addr12;
      logic [7:0] wdata;
      logic [3:0] literal;
      logic flags_req;
   } dmau_req_t;

   typedef struct packed {
      logic valid;
      logic [7:0] rdata;
      logic flag_update;
   } dmau_rsp_t;

   typedef struct packed {
      logic en;
      logic we;
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
   } dmau_ram_t;
endpackage

/* tb/dmau_ram_model.sv */
// data ram model on the far side of the address unit
`timescale 1ns/1ps
`default_nettype none
module dmau_ram_model
   import dmau_pkg::*;
(
   input wire logic clk_sys,
   input wire dmau_ram_t ram_req,
   output logic [7:0] ram_rdata
);
   // sixteen banks of 256 bytes, one flat static array
   logic [7:0] mem [0:4095];
   logic [7:0] idle_q = 8'ha5;
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'(i) ^ 8'h5a;
      end
   end
   // the unit takes read data while its enable stands, so the array reads through;
   // idle cycles show toggling data so a sample in the wrong cycle is caught
   assign ram_rdata = ram_req.en ? mem[ram_req.addr] : idle_q;
   always @(posedge clk_sys) begin
      idle_q <= ~idle_q;
      if (ram_req.en && ram_req.we) begin
         mem[ram_req.addr] <= ram_req.wdata;
      end
   end
endmodule
`default_nettype wire

/* tb/dmau_core_test.sv */
// self-checking bench of the data memory address unit
`timescale 1ns/1ps
`default_nettype none
module dmau_core_test
   import dmau_pkg::*;
;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   dmau_req_t core_req = '0;
   dmau_rsp_t core_rsp;
   dmau_ram_t ram_req;
   logic [7:0] ram_rdata;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   int n_errors = 0;
   int samples_checked = 0;
   logic [7:0] d;
   logic f;
   logic [31:0] w;
   logic [11:0] a;

   dmau_core u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .core_req(core_req), .core_rsp(core_rsp),
      .ram_req(ram_req), .ram_rdata(ram_rdata), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
   dmau_ram_model u_ram (.clk_sys(clk_sys), .ram_req(ram_req), .ram_rdata(ram_rdata));

   initial begin
      forever #2 clk_sys = ~clk_sys;
   end

   task summarize;
      if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task chk_wb(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: bus data %h, expected %h", $time, got, exp);
      end
   endtask

   task chk_core(input logic [8:0] got, input logic [8:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: flag and data %h, expected %h", $time, got, exp);
      end
   endtask

   // classic cycle: hold everything until ack is sampled, then idle one cycle
   task wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
      int n;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= sel;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 16);
      if (n >= 16) chk_wb(32'hdead, 32'h0);
      w = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_sys);
   endtask

   // one core request; loads give no answer, reads and writes wait for valid
   task core(input dmau_op_t op, input logic acc, input logic [7:0] fa, input logic full,
             input logic [11:0] a12, input logic [7:0] wd, input logic [3:0] lit);
      int n;
      core_req <= '{op, full, acc, fa, a12, wd, lit, 1'b1};
      @(posedge clk_sys);
      core_req <= '0;
      d = 8'hxx;
      f = 1'bx;
      n = 0;
      while (op != OP_LOAD_BANK && n < 8) begin
         @(posedge clk_sys);
         n++;
         if (core_rsp.valid === 1'b1) begin
            d = core_rsp.rdata;
            f = core_rsp.flag_update;
            n = 99;
         end
      end
      if (n == 8) chk_core(9'h1ff, 9'h0);
      @(posedge clk_sys);
   endtask

   initial begin
      #100000;
      n_errors++;
      summarize();
   end

   initial begin
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      wb_xfer(0, 8'h00, 0, 4'h1); chk_wb(w, 32'h0);
      wb_xfer(0, 8'h1c, 0, 4'h3); chk_wb(w, 32'hffff);
      wb_xfer(0, 8'h24, 0, 4'hf); chk_wb(w, 32'h0);
      wb_xfer(1, 8'h00, 32'hf3, 4'h1);
      wb_xfer(0, 8'h00, 0, 4'h1); chk_wb(w, 32'h03);
      core(OP_READ, 1, 8'h10, 0, 0, 0, 0); chk_core({f, d}, {1'b1, 8'h10 ^ 8'h5a});
      core(OP_WRITE, 1, 8'h11, 0, 0, 8'hc4, 0); chk_core(u_ram.mem[12'h311], 9'hc4);
      core(OP_LOAD_BANK, 1, 0, 0, 0, 0, 4'h5);
      wb_xfer(0, 8'h00, 0, 4'h1); chk_wb(w, 32'h05);
      core(OP_WRITE, 1, 8'hff, 0, 0, 8'h77, 0); chk_core(u_ram.mem[12'h5ff], 9'h77);
      core(OP_WRITE, 0, 8'h7f, 0, 0, 8'h31, 0); chk_core(u_ram.mem[12'h07f], 9'h31);
      core(OP_WRITE, 0, 8'h80, 0, 0, 8'h32, 0); chk_core(u_ram.mem[12'hf80], 9'h32);
      core(OP_WRITE, 1, 8'h80, 0, 0, 8'h33, 0); chk_core(u_ram.mem[12'h580], 9'h33);
      core(OP_WRITE, 1, 8'h22, 1, 12'habc, 8'h99, 0); chk_core(u_ram.mem[12'habc], 9'h99);
      for (int i = 0; i < 3; i++) begin
         a = {4'(i * 5 + 1), 8'(8'h40 + i)};
         wb_xfer(1, 8'(8'h04 + 8 * i), {24'h0, a[7:0]}, 4'h1);
         wb_xfer(1, 8'(8'h08 + 8 * i), {24'h0, 4'hf, a[11:8]}, 4'h1);
         wb_xfer(0, 8'(8'h08 + 8 * i), 0, 4'h1); chk_wb(w, {28'h0, a[11:8]});
         core(OP_WRITE, 0, 8'(8'he8 + i), 0, 0, 8'(8'h60 + i), 0);
         chk_core(u_ram.mem[a], {1'b0, 8'(8'h60 + i)});
      end
      core(OP_WRITE, 0, 8'he1, 0, 0, 8'h22, 0);
      core(OP_WRITE, 0, 8'he2, 0, 0, 8'h0e, 0);
      wb_xfer(0, 8'h04, 0, 4'h1); chk_wb(w, 32'h22);
      core(OP_READ, 0, 8'he2, 0, 0, 0, 0); chk_core({f, d}, {1'b1, 8'h0e});
      core(OP_READ, 0, 8'he8, 0, 0, 0, 0); chk_core({f, d}, {1'b1, 8'h22 ^ 8'h5a});
      // pointer 2 aimed at its own port
      wb_xfer(1, 8'h14, 32'hea, 4'h1);
      wb_xfer(1, 8'h18, 32'h0f, 4'h1);
      core(OP_READ, 0, 8'hea, 0, 0, 0, 0); chk_core({f, d}, {1'b1, 8'h00});
      core(OP_WRITE, 0, 8'hea, 0, 0, 8'h55, 0); chk_core({f, 8'h00}, 9'h000);
      wb_xfer(0, 8'h20, 0, 4'hf); chk_wb(w & 32'h1000, 32'h1000);
      chk_core(u_ram.mem[12'hfea], {1'b0, 8'hea ^ 8'h5a});
      // switch bank 1 off
      wb_xfer(1, 8'h1c, 32'hfffd, 4'h3);
      core(OP_READ, 0, 0, 1, 12'h150, 0, 0); chk_core({f, d}, {1'b1, 8'h00});
      core(OP_WRITE, 0, 0, 1, 12'h151, 8'h11, 0); chk_core(u_ram.mem[12'h151], {1'b0, 8'h51 ^ 8'h5a});
      // core write to the selector through the common bank keeps only the low nibble
      core(OP_WRITE, 0, 8'he0, 0, 0, 8'h9c, 0);
      wb_xfer(0, 8'h00, 0, 4'h1); chk_wb(w, 32'h0c);
      summarize();
   end
endmodule
`default_nettype wire
